// file: design/lpsv_defs.svh
// lpsv_defs.svh: constants for the low-power snoop and operating-point sequencer
// assumes: included by bare name from every design file that needs it
`ifndef LPSV_DEFS_SVH
`define LPSV_DEFS_SVH

// ------------------------------------------------------------
// widths
// ------------------------------------------------------------
`define LPSV_VID_W        8
`define LPSV_RATIO_W      6
`define LPSV_SETTLE_W     12

// ------------------------------------------------------------
// reset values and step sizes
// ------------------------------------------------------------
`define LPSV_VID_RST      8'h20
`define LPSV_RATIO_RST    6'h06
`define LPSV_VID_STEP     8'h01
`define LPSV_STEP_UV      12500
`define LPSV_SETTLE_RST   12'h010

`endif

// file: design/lpsv_pkg.sv
// lpsv_pkg.sv: types shared by the sequencer and its helpers
// assumes: lpsv_defs.svh is on the include path
`default_nettype none
`include "lpsv_defs.svh"

package lpsv_pkg;

	typedef logic [`LPSV_VID_W-1:0]   lpsv_vid_t;
	typedef logic [`LPSV_RATIO_W-1:0] lpsv_ratio_t;

	// one operating point: core ratio plus voltage code
	typedef struct packed {
		lpsv_ratio_t ratio;
		lpsv_vid_t   vid;
	} lpsv_point_t;

	// power state machine, one-hot
	typedef enum logic [6:0] {
		LPSV_NORMAL   = 7'b0000001,
		LPSV_HALT     = 7'b0000010,
		LPSV_GRANT    = 7'b0000100,
		LPSV_SNOOP    = 7'b0001000,
		LPSV_ENTER_LP = 7'b0010000,
		LPSV_EXIT_LP  = 7'b0100000,
		LPSV_PCHANGE  = 7'b1000000
	} lpsv_state_t;

	// operating-point change sequence, one-hot
	typedef enum logic [3:0] {
		LPSV_SQ_IDLE  = 4'b0001,
		LPSV_SQ_VUP   = 4'b0010,
		LPSV_SQ_RATIO = 4'b0100,
		LPSV_SQ_VDN   = 4'b1000
	} lpsv_seq_t;

endpackage : lpsv_pkg

`default_nettype wire

// file: design/lpsv_seq.sv
// lpsv_seq.sv: low-power snoop state control and operating-point sequencing
// assumes: one 200 MHz bus clock; snoop and halt/grant inputs arrive from pins
//
// Behaviour
// RULE1 - with extended halt disabled, halt snoops use the ordinary halt snoop state; the code keeps ext set when an extended stop-grant falls back to halt
// RULE2 - in stop-grant or halt, a bus snoop enters the snoop state
// RULE3 - stay in the snoop state until the snoop is serviced by anyone
// RULE4 - after service return to the stop-grant or halt state held before
// RULE5 - extended snoop states keep the reduced ratio and reduced voltage code
// RULE6 - extended snoop states handle snoops exactly as ordinary snoop states
// RULE7 - after an extended snoop return to the extended state left
// RULE8 - package voltage code is the higher request of the two cores
// RULE9 - state changes alter only core ratio and voltage, never bus clock
// RULE10 - performance states are chosen only by software configuration writes
// RULE11 - going faster: step voltage up 12.5 mV at a time, then change ratio
// RULE12 - going slower: change ratio first, then step voltage down 12.5 mV
// RULE13 - requested ratio is clamped to the maximum rated core ratio
// RULE14 - entering extended low power: lower ratio first, then lower voltage
// RULE15 - leaving extended low power: restore voltage first, then ratio
// RULE16 - each voltage step is held a configurable number of bus clocks
//
// Operating notes
// - every pin level passes two flops, so snoops and low-power requests act three clocks late
// - stop-grant is inverted ahead of the flops so that reset reads as no request
// - a new operating point is taken only with the sequencer idle, in the normal state or on leaving an extended state;
//   a request that changes during a move is picked up once that move completes
// - the stepper's done flag is registered, so completion also compares the code itself
// - settle_clks of zero is treated as one; every code then stands for at least two clocks
// - the extended point is clamped to the rated ratio just as software requests are
// - the bus clock is never touched; only the core ratio and the voltage code move
// - a snoop freezes the operating point: the sequencer is always idle in the snoop state
// - when halt and stop-grant both ask, the stop-grant enable picks the flavour
// - leaving an extended state whose original code is not above the low one changes the
//   ratio first and then steps down, the same order as any slow-down
`timescale 1ns/1ps
`default_nettype none
`include "lpsv_defs.svh"

module lpsv_seq (
	input  wire logic                      clk,
	input  wire logic                      rstn,
	// async pin levels from the bus side
	input  wire logic                      halt_req,      // all cores halted
	input  wire logic                      stop_clk_n,    // stop-grant request, low active
	input  wire logic                      snoop_active,  // snoop in progress on the front_side_bus
	// configuration, same-clock logic
	input  wire logic                      ext_halt_en,
	input  wire logic                      ext_grant_en,
	input  wire lpsv_pkg::lpsv_point_t     core0_req,     // from perf_config_register of core 0
	input  wire lpsv_pkg::lpsv_point_t     core1_req,     // from perf_config_register of core 1
	input  wire lpsv_pkg::lpsv_point_t     low_point,     // extended low-power operating point
	input  wire lpsv_pkg::lpsv_ratio_t     max_ratio,     // rated top ratio
	input  wire logic [`LPSV_SETTLE_W-1:0] settle_clks,
	// outputs
	output lpsv_pkg::lpsv_vid_t            voltage_id_code,
	output lpsv_pkg::lpsv_ratio_t          core_ratio,
	output lpsv_pkg::lpsv_state_t          power_state,
	output logic                           in_snoop,
	output logic                           ext_active,
	output logic                           busy
);

	// ------------------------------------------------------------
	// pin synchronisation
	// ------------------------------------------------------------
	logic [2:0] pins_s;
	logic       halt_s;
	logic       grant_s;
	logic       snoop_s;

	// stop-grant is inverted ahead of the flops so reset reads as no request
	lpsv_sync #(.W(3)) u_sync (
		.clk  (clk),
		.rstn (rstn),
		.din  ({halt_req, ~stop_clk_n, snoop_active}),
		.dout (pins_s)
	);

	assign halt_s  = pins_s[2];
	assign grant_s = pins_s[1];
	assign snoop_s = pins_s[0];

	// ------------------------------------------------------------
	// target operating point
	// ------------------------------------------------------------
	lpsv_pkg::lpsv_point_t pkg_req;
	lpsv_pkg::lpsv_point_t lim_req;
	lpsv_pkg::lpsv_point_t lim_low;
	lpsv_pkg::lpsv_vid_t   vid_step;
	logic                  vid_done;

	// highest voltage of either core wins; ratio follows the faster core
	always_comb begin
		pkg_req.vid   = (core0_req.vid > core1_req.vid) ? core0_req.vid : core1_req.vid;       // RULE8
		pkg_req.ratio = (core0_req.ratio > core1_req.ratio) ? core0_req.ratio : core1_req.ratio;
		lim_req       = pkg_req;
		if (pkg_req.ratio > max_ratio) begin
			lim_req.ratio = max_ratio;                                                          // RULE13
		end
		lim_low = low_point;
		if (low_point.ratio > max_ratio) begin
			lim_low.ratio = max_ratio;                                                          // RULE13
		end
	end

	// ------------------------------------------------------------
	// power state machine
	// ------------------------------------------------------------
	lpsv_pkg::lpsv_state_t state;
	lpsv_pkg::lpsv_state_t next_state;
	lpsv_pkg::lpsv_state_t ret_state;       // halt or grant to return to after a snoop
	lpsv_pkg::lpsv_state_t next_ret_state;
	logic                  ext;             // extended low point in force
	logic                  next_ext;
	lpsv_pkg::lpsv_point_t cur;             // point last committed to the ratio
	lpsv_pkg::lpsv_point_t next_cur;
	lpsv_pkg::lpsv_point_t goal;            // point being sequenced to
	lpsv_pkg::lpsv_point_t next_goal;
	lpsv_pkg::lpsv_seq_t   sq;
	lpsv_pkg::lpsv_seq_t   next_sq;
	lpsv_pkg::lpsv_vid_t   vid_target;
	lpsv_pkg::lpsv_vid_t   next_vid_target;
	logic                  want_lp;
	logic                  want_ext;
	logic                  at_goal;         // stepper settled on the goal code

	// extended flavour depends on which state is being entered
	always_comb begin
		want_lp  = halt_s | grant_s;
		want_ext = grant_s ? ext_grant_en : ext_halt_en;     // RULE1
	end

	// done is a registered flag and still speaks of the old target for one clock
	// after a new one is set, so the settled test also compares the code itself
	always_comb begin
		at_goal = vid_done && (vid_step == goal.vid);          // RULE16
	end

	// ordering: ratio before voltage when slowing, voltage before ratio when speeding up
	always_comb begin
		next_state      = state;
		next_ret_state  = ret_state;
		next_ext        = ext;
		next_cur        = cur;
		next_goal       = goal;
		next_sq         = sq;
		next_vid_target = vid_target;

		// operating-point sequencer
		unique case (sq)
			lpsv_pkg::LPSV_SQ_IDLE: begin
				next_sq = lpsv_pkg::LPSV_SQ_IDLE;
			end
			lpsv_pkg::LPSV_SQ_VUP: begin
				if (at_goal) begin
					next_sq = lpsv_pkg::LPSV_SQ_RATIO;              // RULE11 RULE15
				end
			end
			lpsv_pkg::LPSV_SQ_RATIO: begin
				// ratio is committed here; the voltage follows only if the goal is lower
				next_cur.ratio = goal.ratio;                        // RULE9
				if (goal.vid < vid_target) begin
					next_vid_target = goal.vid;
					next_sq         = lpsv_pkg::LPSV_SQ_VDN;        // RULE12 RULE14
				end else begin
					next_cur.vid = goal.vid;
					next_sq      = lpsv_pkg::LPSV_SQ_IDLE;
				end
			end
			lpsv_pkg::LPSV_SQ_VDN: begin
				if (at_goal) begin
					next_cur.vid = goal.vid;
					next_sq      = lpsv_pkg::LPSV_SQ_IDLE;
				end
			end
		endcase

		// power state machine
		unique case (state)
			lpsv_pkg::LPSV_NORMAL: begin
				if (sq == lpsv_pkg::LPSV_SQ_IDLE) begin
					if (want_lp && want_ext) begin
						next_goal  = lim_low;
						next_ext   = 1'b1;
						next_state = lpsv_pkg::LPSV_ENTER_LP;
						next_sq    = lpsv_pkg::LPSV_SQ_RATIO;       // RULE14
					end else if (want_lp) begin
						next_state = grant_s ? lpsv_pkg::LPSV_GRANT : lpsv_pkg::LPSV_HALT;
					end else if (lim_req != cur) begin
						next_goal  = lim_req;                       // RULE10
						next_state = lpsv_pkg::LPSV_PCHANGE;
						if (lim_req.vid > vid_target) begin
							next_vid_target = lim_req.vid;
							next_sq         = lpsv_pkg::LPSV_SQ_VUP;    // RULE11
						end else begin
							next_sq = lpsv_pkg::LPSV_SQ_RATIO;      // RULE12
						end
					end
				end
			end
			lpsv_pkg::LPSV_PCHANGE, lpsv_pkg::LPSV_ENTER_LP, lpsv_pkg::LPSV_EXIT_LP: begin
				if (sq == lpsv_pkg::LPSV_SQ_IDLE) begin
					if (state == lpsv_pkg::LPSV_ENTER_LP) begin
						next_state = grant_s ? lpsv_pkg::LPSV_GRANT : lpsv_pkg::LPSV_HALT;
					end else begin
						next_state = lpsv_pkg::LPSV_NORMAL;
					end
				end
			end
			lpsv_pkg::LPSV_HALT, lpsv_pkg::LPSV_GRANT: begin
				if (snoop_s) begin
					next_ret_state = state;                         // RULE4 RULE7
					next_state     = lpsv_pkg::LPSV_SNOOP;          // RULE2 RULE6
				end else if (!want_lp) begin
					if (ext) begin
						next_goal  = lim_req;
						next_ext   = 1'b0;
						next_state = lpsv_pkg::LPSV_EXIT_LP;
						if (lim_req.vid > vid_target) begin
							next_vid_target = lim_req.vid;
							next_sq         = lpsv_pkg::LPSV_SQ_VUP;    // RULE15
						end else begin
							// original code not above the low one: ratio first, then step down
							next_sq = lpsv_pkg::LPSV_SQ_RATIO;      // RULE15
						end
					end else begin
						next_state = lpsv_pkg::LPSV_NORMAL;
					end
				end else if (grant_s && state == lpsv_pkg::LPSV_HALT) begin
					next_state = lpsv_pkg::LPSV_GRANT;
				end else if (!grant_s && state == lpsv_pkg::LPSV_GRANT) begin
					next_state = lpsv_pkg::LPSV_HALT;
				end
			end
			lpsv_pkg::LPSV_SNOOP: begin
				// point untouched while snooping; the sequencer is idle here
				if (!snoop_s) begin
					next_state = ret_state;                         // RULE3 RULE4 RULE5 RULE7
				end
			end
			default: begin
				next_state = lpsv_pkg::LPSV_NORMAL;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state      <= lpsv_pkg::LPSV_NORMAL;
			ret_state  <= lpsv_pkg::LPSV_HALT;
			ext        <= 1'b0;
			cur        <= {`LPSV_RATIO_RST, `LPSV_VID_RST};
			goal       <= {`LPSV_RATIO_RST, `LPSV_VID_RST};
			sq         <= lpsv_pkg::LPSV_SQ_IDLE;
			vid_target <= `LPSV_VID_RST;
		end else begin
			state      <= next_state;
			ret_state  <= next_ret_state;
			ext        <= next_ext;
			cur        <= next_cur;
			goal       <= next_goal;
			sq         <= next_sq;
			vid_target <= next_vid_target;
		end
	end

	// ------------------------------------------------------------
	// voltage stepping
	// ------------------------------------------------------------
	lpsv_vid_step u_step (
		.clk    (clk),
		.rstn   (rstn),
		.target (vid_target),
		.settle ((settle_clks == '0) ? `LPSV_SETTLE_W'(1) : settle_clks),
		.vid    (vid_step),
		.done   (vid_done)
	);

	// ------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------
	// the bus clock is not touched; only ratio and voltage code are driven
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			voltage_id_code <= `LPSV_VID_RST;
			core_ratio      <= `LPSV_RATIO_RST;
			power_state     <= lpsv_pkg::LPSV_NORMAL;
			in_snoop        <= 1'b0;
			ext_active      <= 1'b0;
			busy            <= 1'b0;
		end else begin
			voltage_id_code <= vid_step;
			core_ratio      <= next_cur.ratio;                      // RULE9
			power_state     <= next_state;
			in_snoop        <= (next_state == lpsv_pkg::LPSV_SNOOP);
			ext_active      <= next_ext;
			busy            <= (next_sq != lpsv_pkg::LPSV_SQ_IDLE);
		end
	end

endmodule // lpsv_seq

`default_nettype wire

// file: design/lpsv_sync.sv
// lpsv_sync.sv: two-flop synchroniser for a bundle of pin levels
// assumes: inputs are asynchronous levels; output lags by two clocks
`timescale 1ns/1ps
`default_nettype none

module lpsv_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	logic [W-1:0] meta;

	// first stage feeds only the second stage
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta <= '0;
			dout <= '0;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end

endmodule // lpsv_sync

`default_nettype wire

// file: design/lpsv_vid_step.sv
// lpsv_vid_step.sv: walks a voltage code to a target one step at a time
// assumes: target is held stable while busy; settle count is at least one
`timescale 1ns/1ps
`default_nettype none
`include "lpsv_defs.svh"

module lpsv_vid_step (
	input  wire logic                      clk,
	input  wire logic                      rstn,
	input  wire lpsv_pkg::lpsv_vid_t       target,
	input  wire logic [`LPSV_SETTLE_W-1:0] settle,
	output lpsv_pkg::lpsv_vid_t            vid,
	output logic                           done
);

	lpsv_pkg::lpsv_vid_t       next_vid;
	logic [`LPSV_SETTLE_W-1:0] cnt;
	logic [`LPSV_SETTLE_W-1:0] next_cnt;
	logic                      next_done;

	// each code moves the rail by one 12.5 mV step; hold each for settle clocks plus one
	always_comb begin
		next_vid  = vid;
		next_cnt  = cnt;
		next_done = 1'b0;
		if (cnt != '0) begin
			next_cnt = cnt - `LPSV_SETTLE_W'(1);                    // RULE16
		end else if (target > vid) begin
			next_vid = vid + `LPSV_VID_STEP;                        // RULE11
			next_cnt = settle;                                      // RULE16
		end else if (target < vid) begin
			next_vid = vid - `LPSV_VID_STEP;                        // RULE12
			next_cnt = settle;                                      // RULE16
		end else begin
			next_done = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			vid  <= `LPSV_VID_RST;
			cnt  <= '0;
			done <= 1'b0;
		end else begin
			vid  <= next_vid;
			cnt  <= next_cnt;
			done <= next_done;
		end
	end

endmodule // lpsv_vid_step

`default_nettype wire

// file: test/lpsv_fsb_agent.sv
// lpsv_fsb_agent.sv: far bus agent that holds a snoop outstanding
// assumes: bench pulses snoop_go for one clock with the length to hold
`timescale 1ns/1ps
`default_nettype none

module lpsv_fsb_agent (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       snoop_go,
	input  wire logic [7:0] snoop_len,
	output logic            snoop_active
);
	logic [7:0] cnt;
	logic [7:0] next_cnt;

	// count down the snoop; a short length models a prompt agent, a long one a slow agent
	always_comb begin
		next_cnt = cnt;
		if (snoop_go) begin
			next_cnt = snoop_len;
		end else if (cnt != 8'h00) begin
			next_cnt = cnt - 8'h01;
		end
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt <= 8'h00;
		end else begin
			cnt <= next_cnt;
		end
	end
	assign snoop_active = (cnt != 8'h00);
endmodule // lpsv_fsb_agent
`default_nettype wire

// file: test/lpsv_seq_bench.sv
// lpsv_seq_bench.sv: self-checking bench for the low-power sequencer
// assumes: design files and lpsv_fsb_agent compiled first
`timescale 1ns/1ps
`default_nettype none
`include "lpsv_defs.svh"

module lpsv_seq_bench;
	logic                      clk          = 1'b0;
	logic                      rstn         = 1'b0;
	logic                      halt_req     = 1'b0;
	logic                      stop_clk_n   = 1'b1;
	logic                      ext_halt_en  = 1'b0;
	logic                      ext_grant_en = 1'b0;
	lpsv_pkg::lpsv_point_t     core0_req    = {6'h06, 8'h20};
	lpsv_pkg::lpsv_point_t     core1_req    = {6'h06, 8'h20};
	lpsv_pkg::lpsv_point_t     low_point    = {6'h04, 8'h1E};
	lpsv_pkg::lpsv_ratio_t     max_ratio    = 6'h09;
	logic [`LPSV_SETTLE_W-1:0] settle_clks  = 12'h002;
	logic                      snoop_go     = 1'b0;
	logic [7:0]                snoop_len    = 8'h00;
	logic                      snoop_active;
	lpsv_pkg::lpsv_vid_t       voltage_id_code;
	lpsv_pkg::lpsv_ratio_t     core_ratio;
	lpsv_pkg::lpsv_state_t     power_state;
	logic                      in_snoop;
	logic                      ext_active;
	logic                      busy;
	int                        miscompares  = 0;
	int                        n_checks     = 0;
	int                        cycles       = 0;

	always #2.5 clk = ~clk;

	lpsv_seq lpsv_seq_inst (.clk(clk), .rstn(rstn), .halt_req(halt_req), .stop_clk_n(stop_clk_n),
		.snoop_active(snoop_active), .ext_halt_en(ext_halt_en), .ext_grant_en(ext_grant_en),
		.core0_req(core0_req), .core1_req(core1_req), .low_point(low_point), .max_ratio(max_ratio),
		.settle_clks(settle_clks), .voltage_id_code(voltage_id_code), .core_ratio(core_ratio),
		.power_state(power_state), .in_snoop(in_snoop), .ext_active(ext_active), .busy(busy));
	lpsv_fsb_agent lpsv_fsb_agent_inst (.clk(clk), .rstn(rstn), .snoop_go(snoop_go),
		.snoop_len(snoop_len), .snoop_active(snoop_active));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// waits for a settled point; order is judged on every cycle of the way
	task automatic settle_to(input lpsv_pkg::lpsv_state_t st, input lpsv_pkg::lpsv_ratio_t r,
			input lpsv_pkg::lpsv_vid_t v, input logic up);
		lpsv_pkg::lpsv_ratio_t r0;
		lpsv_pkg::lpsv_vid_t   v0;
		r0 = core_ratio;
		v0 = voltage_id_code;
		for (int i = 0; i < 300; i++) begin
			@(negedge clk);
			if (up && core_ratio !== r0 && voltage_id_code !== v) chk("order_up", v, voltage_id_code);
			if (!up && voltage_id_code !== v0 && core_ratio !== r) chk("order_dn", r, core_ratio);
			if (power_state === st && busy === 1'b0 && core_ratio === r && voltage_id_code === v) break;
		end
		chk("state", st, power_state);
		chk("ratio", r, core_ratio);
		chk("vid", v, voltage_id_code);
	endtask

	task automatic wait_snoop(input logic lvl);
		for (int i = 0; i < 40 && in_snoop !== lvl; i++) @(negedge clk);
		chk("in_snoop", lvl, in_snoop);
	endtask

	task automatic do_snoop(input logic [7:0] len);
		snoop_go = 1'b1;
		snoop_len = len;
		@(negedge clk);
		snoop_go = 1'b0;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_idle();
		repeat (20) @(negedge clk);
		settle_to(lpsv_pkg::LPSV_NORMAL, 6'h06, 8'h20, 1'b0);
		$display("test idle done");
	endtask

	task automatic t_up();
		core0_req = {6'h08, 8'h21};
		core1_req = {6'h07, 8'h22};
		@(negedge clk);
		chk("busy", 1'b1, busy);
		settle_to(lpsv_pkg::LPSV_NORMAL, 6'h08, 8'h22, 1'b1);
		$display("test speed up done");
	endtask

	task automatic t_halt();
		ext_grant_en = 1'b1; // only the halt flavour's enable may govern a halt
		halt_req = 1'b1;
		settle_to(lpsv_pkg::LPSV_HALT, 6'h08, 8'h22, 1'b0);
		do_snoop(8'h0C);
		wait_snoop(1'b1);
		chk("ext_active", 1'b0, ext_active);
		wait_snoop(1'b0);
		chk("state", lpsv_pkg::LPSV_HALT, power_state);
		halt_req = 1'b0;
		settle_to(lpsv_pkg::LPSV_NORMAL, 6'h08, 8'h22, 1'b0);
		$display("test halt snoop done");
	endtask

	task automatic t_clamp();
		core0_req = {6'h0C, 8'h23};
		settle_to(lpsv_pkg::LPSV_NORMAL, 6'h09, 8'h23, 1'b1);
		$display("test clamp done");
	endtask

	task automatic t_down();
		core0_req = {6'h06, 8'h20};
		core1_req = {6'h06, 8'h20};
		settle_to(lpsv_pkg::LPSV_NORMAL, 6'h06, 8'h20, 1'b0);
		$display("test slow down done");
	endtask

	task automatic t_ext();
		ext_grant_en = 1'b1;
		stop_clk_n = 1'b0;
		settle_to(lpsv_pkg::LPSV_GRANT, 6'h04, 8'h1E, 1'b0);
		chk("ext_active", 1'b1, ext_active);
		do_snoop(8'h03);
		wait_snoop(1'b1);
		chk("ratio", 6'h04, core_ratio);
		chk("vid", 8'h1E, voltage_id_code);
		wait_snoop(1'b0);
		chk("state", lpsv_pkg::LPSV_GRANT, power_state);
		stop_clk_n = 1'b1;
		settle_to(lpsv_pkg::LPSV_NORMAL, 6'h06, 8'h20, 1'b1);
		ext_halt_en = 1'b1;
		halt_req = 1'b1;
		settle_to(lpsv_pkg::LPSV_HALT, 6'h04, 8'h1E, 1'b0);
		chk("ext_active", 1'b1, ext_active);
		halt_req = 1'b0;
		settle_to(lpsv_pkg::LPSV_NORMAL, 6'h06, 8'h20, 1'b1);
		$display("test extended grant and halt done");
	endtask

	// ----------------------------------------
	// verdict, sequence and hang guard
	// ----------------------------------------
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		repeat (16) @(negedge clk);
		rstn = 1'b1;
		t_idle();
		t_up();
		t_halt();
		t_clamp();
		t_down();
		t_ext();
		summarize();
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			summarize();
		end
	end
endmodule // lpsv_seq_bench
`default_nettype wire

// file: test/lpsv_seq_checker.sv
// lpsv_seq_checker.sv: port-level assertions for the low-power sequencer
// assumes: bound to lpsv_seq; the bench holds settle_clks at 2
`timescale 1ns/1ps
`default_nettype none
`include "lpsv_defs.svh"

module lpsv_seq_checker (
	input wire logic                      clk,
	input wire logic                      rstn,
	input wire logic                      halt_req,
	input wire logic                      stop_clk_n,
	input wire logic                      snoop_active,
	input wire logic                      ext_halt_en,
	input wire logic                      ext_grant_en,
	input wire lpsv_pkg::lpsv_point_t     core0_req,
	input wire lpsv_pkg::lpsv_point_t     core1_req,
	input wire lpsv_pkg::lpsv_point_t     low_point,
	input wire lpsv_pkg::lpsv_ratio_t     max_ratio,
	input wire logic [`LPSV_SETTLE_W-1:0] settle_clks,
	input wire lpsv_pkg::lpsv_vid_t       voltage_id_code,
	input wire lpsv_pkg::lpsv_ratio_t     core_ratio,
	input wire lpsv_pkg::lpsv_state_t     power_state,
	input wire logic                      in_snoop,
	input wire logic                      ext_active,
	input wire logic                      busy
);
	lpsv_pkg::lpsv_state_t last_lp;
	lpsv_pkg::lpsv_state_t next_last_lp;

	// ----------------------------------------
	// remember the low-power state a snoop interrupts
	// ----------------------------------------
	always_comb begin
		next_last_lp = last_lp;
		if (!in_snoop && (power_state == lpsv_pkg::LPSV_HALT || power_state == lpsv_pkg::LPSV_GRANT)) begin
			next_last_lp = power_state;
		end
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			last_lp <= lpsv_pkg::LPSV_NORMAL;
		end else begin
			last_lp <= next_last_lp;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	// one code per step keeps each move at 12.5 mV
	property p_vid_step;
		$changed(voltage_id_code) |-> (voltage_id_code == $past(voltage_id_code) + 8'h01)
			|| (voltage_id_code + 8'h01 == $past(voltage_id_code));
	endproperty
	a_vid_step: assert property (p_vid_step) else $error("voltage code moved more than one step");
	property p_settle;
		$changed(voltage_id_code) && settle_clks == 12'h002 |=> $stable(voltage_id_code)[*2];
	endproperty
	a_settle: assert property (p_settle) else $error("voltage step held too briefly");
	// a ratio rise must come after the last voltage step
	property p_up_order;
		core_ratio > $past(core_ratio) |-> $stable(voltage_id_code) ##1 $stable(voltage_id_code)[*3];
	endproperty
	a_up_order: assert property (p_up_order) else $error("voltage rose after ratio");
	property p_dn_order;
		voltage_id_code < $past(voltage_id_code) |=> (core_ratio >= $past(core_ratio))[*3];
	endproperty
	a_dn_order: assert property (p_dn_order) else $error("ratio fell after voltage");
	property p_snoop_enter;
		$rose(snoop_active) && (power_state == lpsv_pkg::LPSV_HALT || power_state == lpsv_pkg::LPSV_GRANT)
			|-> ##3 in_snoop && power_state == lpsv_pkg::LPSV_SNOOP;
	endproperty
	a_snoop_enter: assert property (p_snoop_enter) else $error("snoop not entered");
	property p_snoop_hold;
		in_snoop && $past(snoop_active, 2) |=> in_snoop;
	endproperty
	a_snoop_hold: assert property (p_snoop_hold) else $error("snoop left early");
	property p_snoop_ret;
		$fell(in_snoop) |-> power_state == last_lp;
	endproperty
	a_snoop_ret: assert property (p_snoop_ret) else $error("wrong state after snoop");
	property p_snoop_point;
		in_snoop |-> $stable(core_ratio) && $stable(voltage_id_code) && $stable(ext_active);
	endproperty
	a_snoop_point: assert property (p_snoop_point) else $error("operating point moved in snoop");
	property p_plain_halt;
		in_snoop && !ext_halt_en && (!ext_grant_en || last_lp == lpsv_pkg::LPSV_HALT) |-> !ext_active;
	endproperty
	a_plain_halt: assert property (p_plain_halt) else $error("extended snoop while disabled");
	property p_ratio_cap;
		core_ratio <= max_ratio;
	endproperty
	a_ratio_cap: assert property (p_ratio_cap) else $error("ratio above rated top");

	c_ext_snoop: cover property (in_snoop && ext_active);
	c_plain_snoop: cover property (in_snoop && !ext_active);
	c_speed_up: cover property (!busy && core_ratio > $past(core_ratio));
endmodule // lpsv_seq_checker

bind lpsv_seq lpsv_seq_checker lpsv_seq_checker_inst (.clk(clk), .rstn(rstn), .halt_req(halt_req),
	.stop_clk_n(stop_clk_n), .snoop_active(snoop_active), .ext_halt_en(ext_halt_en),
	.ext_grant_en(ext_grant_en), .core0_req(core0_req), .core1_req(core1_req), .low_point(low_point),
	.max_ratio(max_ratio), .settle_clks(settle_clks), .voltage_id_code(voltage_id_code),
	.core_ratio(core_ratio), .power_state(power_state), .in_snoop(in_snoop), .ext_active(ext_active),
	.busy(busy));
`default_nettype wire
